// File: iofp_pkg.sv
// Shared constants and carrier types of the I/O mapped flash address port.
package iofp_pkg;

    // ************************************************************
    // Host channel widths and port group layout
    // ************************************************************
    localparam int HOST_ADDR_W     = 10;
    localparam int HOST_DATA_W     = 16;
    localparam int PORT_SEL_W      = 3;
    localparam int PORT_COUNT      = 8;
    localparam int PORT_ADDR_LOW   = 0;
    localparam int PORT_ADDR_HIGH  = 1;
    localparam int PORT_ACCESS     = 2;
    localparam int PORT_STREAM     = 3;

    // ************************************************************
    // Flash side layout
    // ************************************************************
    localparam int FLASH_ADDR_W    = 32;
    localparam int NIBBLE_W        = 4;
    localparam int CE_SEL_W        = 3;
    localparam int CE_COUNT        = 8;
    localparam int DEV_ADDR_W_DEF  = 22;

    // ************************************************************
    // Reset values
    // ************************************************************
    localparam logic [FLASH_ADDR_W-1:0] ADDR_RESET = 32'h0000_0000;
    localparam logic [HOST_DATA_W-1:0]  DATA_RESET = 16'h0000;

    typedef struct packed {
        logic [HOST_ADDR_W-1:0] addr;
        logic                   aen;
        logic                   iorN;
        logic                   iowN;
        logic [HOST_DATA_W-1:0] data;
    } iofp_host_s;

    localparam iofp_host_s HOST_IDLE = '{addr: '0, aen: 1'b1, iorN: 1'b1, iowN: 1'b1,
                                         data: DATA_RESET};

    typedef struct packed {
        logic [CE_COUNT-1:0] ceN;
        logic                oeN;
        logic                weN;
        logic                xcvrEnN;
    } iofp_flash_ctl_s;

    localparam iofp_flash_ctl_s FLASH_IDLE = '{ceN: '1, oeN: 1'b1, weN: 1'b1, xcvrEnN: 1'b1};

    typedef enum logic [2:0] {
        ST_IDLE  = 3'b001,
        ST_READ  = 3'b010,
        ST_WRITE = 3'b100
    } iofp_state_e;

endpackage : iofp_pkg

// File: iofp_sync.sv
// Three-stage input synchroniser with an agreement filter on the last two stages.
`timescale 1ns/100ps
`default_nettype none
module iofp_sync #(
    parameter int               WIDTH   = 1,
    parameter logic [WIDTH-1:0] RST_VAL = '0
) (
    input  wire logic             core_clk, // Block clock.
    input  wire logic             reset_n,  // Asynchronous reset, active low.
    input  wire logic             clkEn,    // Clock enable, freezes state when low.
    input  wire logic [WIDTH-1:0] din,      // Asynchronous input.
    output logic      [WIDTH-1:0] dout      // Filtered synchronous value.
);
    logic [WIDTH-1:0] stage1_r;
    logic [WIDTH-1:0] stage2_r;
    logic [WIDTH-1:0] stage3_r;
    wire              agree = (stage2_r == stage3_r);

    // A value passes on only once two stages agree, so a word caught mid-change is held back.
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            stage1_r <= RST_VAL;
            stage2_r <= RST_VAL;
            stage3_r <= RST_VAL;
            dout     <= RST_VAL;
        end else if (clkEn) begin
            stage1_r <= din;
            stage2_r <= stage1_r;
            stage3_r <= stage2_r;
            if (agree) begin
                dout <= stage3_r;
            end
        end
    end
endmodule : iofp_sync
`default_nettype wire

// File: iofp_port.sv
// Host I/O port group that loads, holds and advances the flash address and gates flash access.
//
// How it works
// - Eight consecutive I/O ports on an eight-aligned base, one-hot decoded from three bits.
// - Port decode is enabled only inside the group and with address-enable low.
// - Writes to ports zero and one load the low and high address halves.
// - The held counter drives the flash address pins and the chip-enable decode.
// - Access to port two enables the chip decode and transceivers for read or write.
// - Without an access the chip enables and transceivers stay off to save power.
// - Port three read returns data, then the counter increments as the read ends.
// - Repeated port three reads step through consecutive addresses without reloading.
`timescale 1ns/100ps
`default_nettype none
module iofp_port
    import iofp_pkg::*;
#(
    parameter logic [HOST_ADDR_W-1:0] IO_BASE    = 10'h300,
    parameter int                     DEV_ADDR_W = DEV_ADDR_W_DEF
) (
    input  wire logic                    core_clk,     // Block clock, 100 MHz.
    input  wire logic                    reset_n,      // Asynchronous reset, active low.
    input  wire logic                    clkEn,        // Clock enable.
    input  wire iofp_host_s              hostIn,       // Host channel pins.
    output logic      [HOST_DATA_W-1:0]  hostDataOut,  // Read data to host.
    output logic                         hostDataOe,   // Host data drive enable.
    input  wire logic [HOST_DATA_W-1:0]  flashDataIn,  // Data from the flash array.
    output logic      [FLASH_ADDR_W-1:0] flashAddr,    // Flash address pins.
    output iofp_flash_ctl_s              flashCtl,     // Chip enables and strobes.
    output logic      [HOST_DATA_W-1:0]  flashDataOut, // Write data to flash.
    output logic                         flashDataOe   // Flash data drive enable.
);

    // ************************************************************
    // Parameter checks
    // ************************************************************
    initial begin
        if (IO_BASE[PORT_SEL_W-1:0] != '0) begin
            $error("Port group base must be aligned to eight.");
        end
        if (DEV_ADDR_W + CE_SEL_W > FLASH_ADDR_W || DEV_ADDR_W < 1) begin
            $error("Device address width does not fit the flash address.");
        end
        if (FLASH_ADDR_W != 2 * HOST_DATA_W || FLASH_ADDR_W % NIBBLE_W != 0) begin
            $error("Flash address must be two host words of whole nibbles.");
        end
    end

    function automatic logic [PORT_COUNT-1:0] decode8(input logic [PORT_SEL_W-1:0] sel);
        logic [PORT_COUNT-1:0] hot;
        hot      = '0;
        hot[sel] = 1'b1;
        return hot;
    endfunction : decode8

    // ************************************************************
    // Input synchronisers
    // ************************************************************
    iofp_host_s             hostF;
    logic [HOST_DATA_W-1:0] flashDataF;

    iofp_sync #(.WIDTH($bits(iofp_host_s)), .RST_VAL(HOST_IDLE)) uHostSync (
        .core_clk (core_clk),
        .reset_n  (reset_n),
        .clkEn    (clkEn),
        .din      (hostIn),
        .dout     (hostF)
    );

    iofp_sync #(.WIDTH(HOST_DATA_W), .RST_VAL(DATA_RESET)) uFlashSync (
        .core_clk (core_clk),
        .reset_n  (reset_n),
        .clkEn    (clkEn),
        .din      (flashDataIn),
        .dout     (flashDataF)
    );

    // ************************************************************
    // Port decode
    // ************************************************************
    wire                  groupHit = (hostF.addr[HOST_ADDR_W-1:PORT_SEL_W] ==
                                      IO_BASE[HOST_ADDR_W-1:PORT_SEL_W]) && !hostF.aen;
    wire [PORT_COUNT-1:0] portHit  = groupHit ? decode8(hostF.addr[PORT_SEL_W-1:0]) : '0;
    wire                  iorAct   = !hostF.iorN;
    wire                  iowAct   = !hostF.iowN;

    iofp_state_e            state_r;
    iofp_state_e            state_nxt;
    logic                   iowPrev_r;
    logic [PORT_COUNT-1:0]  wrPort_r;
    logic [HOST_DATA_W-1:0] wrData_r;
    logic                   streamRd_r;
    logic                   streamRd_nxt;

    // Loads act at the end of the write, as the released write strobe would clock a latch.
    wire writeEnd           = iowPrev_r && !iowAct;
    wire addressLoadStrobeA = writeEnd && wrPort_r[PORT_ADDR_LOW];
    wire addressLoadStrobeB = writeEnd && wrPort_r[PORT_ADDR_HIGH];
    wire readEnd            = (state_r == ST_READ) && !iorAct;
    wire counterPulse       = readEnd && streamRd_r;

    // ************************************************************
    // Access sequencer
    // ************************************************************
    always_comb begin
        state_nxt    = state_r;
        streamRd_nxt = streamRd_r;
        unique case (state_r)
            ST_IDLE: begin
                if (iorAct && (portHit[PORT_ACCESS] || portHit[PORT_STREAM])) begin
                    state_nxt    = ST_READ;
                    streamRd_nxt = portHit[PORT_STREAM];
                end else if (iowAct && portHit[PORT_ACCESS]) begin
                    state_nxt = ST_WRITE;
                end
            end
            ST_READ: begin
                if (!iorAct) begin
                    state_nxt    = ST_IDLE;
                    streamRd_nxt = 1'b0;
                end
            end
            ST_WRITE: begin
                if (!iowAct) begin
                    state_nxt = ST_IDLE;
                end
            end
        endcase
    end

    // ************************************************************
    // Address counter
    // ************************************************************
    logic [FLASH_ADDR_W-1:0] counter_nxt;
    wire  [FLASH_ADDR_W-1:0] counterInc = flashAddr + 32'h0000_0001;

    always_comb begin
        counter_nxt = flashAddr;
        if (addressLoadStrobeA) begin
            counter_nxt[HOST_DATA_W-1:0] = wrData_r;
        end else if (addressLoadStrobeB) begin
            counter_nxt[FLASH_ADDR_W-1:HOST_DATA_W] = wrData_r;
        end else if (counterPulse) begin
            counter_nxt = counterInc;
        end
    end

    // Outputs are computed from next state so pins change with the state, not a cycle after.
    wire                  accessNxt = (state_nxt != ST_IDLE);
    wire [CE_COUNT-1:0]   ceHot     = decode8(counter_nxt[DEV_ADDR_W +: CE_SEL_W]);
    wire iofp_flash_ctl_s ctl_nxt;
    assign ctl_nxt.ceN     = accessNxt ? ~ceHot : '1;
    assign ctl_nxt.oeN     = (state_nxt != ST_READ);
    assign ctl_nxt.weN     = (state_nxt != ST_WRITE);
    assign ctl_nxt.xcvrEnN = !accessNxt;

    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            state_r    <= ST_IDLE;
            streamRd_r <= 1'b0;
            iowPrev_r  <= 1'b0;
            wrPort_r   <= '0;
            wrData_r   <= DATA_RESET;
            flashAddr  <= ADDR_RESET;
            flashCtl   <= FLASH_IDLE;
        end else if (clkEn) begin
            state_r    <= state_nxt;
            streamRd_r <= streamRd_nxt;
            iowPrev_r  <= iowAct;
            if (iowAct) begin
                wrPort_r <= portHit;
                wrData_r <= hostF.data;
            end
            flashAddr  <= counter_nxt;
            flashCtl   <= ctl_nxt;
        end
    end

    // ************************************************************
    // Data paths
    // ************************************************************
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            hostDataOut  <= DATA_RESET;
            hostDataOe   <= 1'b0;
            flashDataOut <= DATA_RESET;
            flashDataOe  <= 1'b0;
        end else if (clkEn) begin
            hostDataOe  <= (state_nxt == ST_READ);
            flashDataOe <= (state_nxt == ST_WRITE);
            if (state_r == ST_READ) begin
                hostDataOut <= flashDataF;
            end
            if (iowAct) begin
                flashDataOut <= hostF.data;
            end
        end
    end

    // ************************************************************
    // Checks
    // ************************************************************
    port_onehot_a: assert property (@(posedge core_clk) disable iff (!reset_n)
        $onehot0(portHit)) else $error("Port decode is not one-hot.");

    aen_block_a: assert property (@(posedge core_clk) disable iff (!reset_n)
        clkEn && hostF.aen && state_r == ST_IDLE |=> state_r == ST_IDLE)
        else $error("Access started with address enable high.");

    load_low_a: assert property (@(posedge core_clk) disable iff (!reset_n)
        clkEn && addressLoadStrobeA |=> flashAddr[HOST_DATA_W-1:0] == $past(wrData_r))
        else $error("Low address half not loaded.");

    load_high_a: assert property (@(posedge core_clk) disable iff (!reset_n)
        clkEn && addressLoadStrobeB |=>
        flashAddr[FLASH_ADDR_W-1:HOST_DATA_W] == $past(wrData_r))
        else $error("High address half not loaded.");

    addr_hold_a: assert property (@(posedge core_clk) disable iff (!reset_n)
        state_r == ST_READ && $past(state_r) == ST_READ |-> $stable(flashAddr))
        else $error("Flash address moved during a read.");

    read_enable_a: assert property (@(posedge core_clk) disable iff (!reset_n)
        state_r == ST_READ |-> !flashCtl.oeN && !flashCtl.xcvrEnN && flashCtl.weN &&
        flashCtl.ceN == ~decode8(flashAddr[DEV_ADDR_W +: CE_SEL_W]))
        else $error("Read did not enable the selected device.");

    write_enable_a: assert property (@(posedge core_clk) disable iff (!reset_n)
        state_r == ST_WRITE |-> !flashCtl.weN && flashDataOe && !hostDataOe)
        else $error("Write did not drive the flash.");

    idle_off_a: assert property (@(posedge core_clk) disable iff (!reset_n)
        state_r == ST_IDLE |-> flashCtl.ceN == '1 && flashCtl.xcvrEnN && !flashDataOe)
        else $error("Array enabled while idle.");

    stream_step_a: assert property (@(posedge core_clk) disable iff (!reset_n)
        clkEn && counterPulse |=> flashAddr == $past(flashAddr) + 32'h0000_0001 ##0
        state_r == ST_IDLE) else $error("Stream read did not advance the address.");

    counter_hold_a: assert property (@(posedge core_clk) disable iff (!reset_n)
        clkEn && !addressLoadStrobeA && !addressLoadStrobeB && !counterPulse |=>
        $stable(flashAddr)) else $error("Address changed without a load or stream read.");

endmodule : iofp_port
`default_nettype wire

// File: iofp_host_model.sv
// Host channel master that runs I/O read and write cycles into the port group.
`timescale 1ns/100ps
`default_nettype none
module iofp_host_model
    import iofp_pkg::*;
#(
    parameter logic [HOST_ADDR_W-1:0] IO_BASE = 10'h300
) (
    input  wire logic       core_clk, // Block clock.
    output var  iofp_host_s hostIn    // Host channel pins.
);
    initial hostIn = HOST_IDLE;

    // Strobe phases are held far beyond the input filter so that no edge is lost.
    task automatic busCycle(input logic [HOST_ADDR_W-1:0] a, input logic en,
                            input logic wr, input logic [HOST_DATA_W-1:0] d);
        @(posedge core_clk);
        #1;
        hostIn.addr = a;
        hostIn.aen  = ~en;
        hostIn.data = d;
        repeat (2) @(posedge core_clk);
        #1;
        if (wr) hostIn.iowN = 1'b0;
        else hostIn.iorN = 1'b0;
        repeat (20) @(posedge core_clk);
        #1;
        hostIn.iowN = 1'b1;
        hostIn.iorN = 1'b1;
        repeat (8) @(posedge core_clk);
        #1;
        hostIn.aen  = 1'b1;
        hostIn.data = ~d;
    endtask : busCycle

    task automatic loadAddr(input logic [FLASH_ADDR_W-1:0] fa);
        busCycle(IO_BASE + 10'h0, 1'b1, 1'b1, fa[15:0]);
        busCycle(IO_BASE + 10'h1, 1'b1, 1'b1, fa[31:16]);
    endtask : loadAddr
endmodule : iofp_host_model
`default_nettype wire

// File: iofp_port_tb_top.sv
// Self-checking testbench of the I/O mapped flash address port.
`timescale 1ns/100ps
`default_nettype none
module iofp_port_tb_top
    import iofp_pkg::*;
;
    localparam logic [HOST_ADDR_W-1:0] BASE = 10'h300;
    logic            core_clk, reset_n, clkEn, hostDataOe, flashDataOe;
    logic            rdOn = 1'b0, wrOn = 1'b0;
    iofp_host_s      hostIn;
    logic [15:0]     hostDataOut, flashDataIn, flashDataOut;
    logic [31:0]     flashAddr, seenAddr;
    iofp_flash_ctl_s flashCtl;
    logic [47:0]     rdQ[$], wrQ[$], seen;
    logic [7:0]      seenCe;
    logic [15:0]     arr [bit [31:0]];
    logic [15:0]     wrote [bit [31:0]];
    int              mismatches, tests_run;

    iofp_port #(.IO_BASE(BASE), .DEV_ADDR_W(DEV_ADDR_W_DEF)) u_iofp_port (
        .core_clk(core_clk), .reset_n(reset_n), .clkEn(clkEn), .hostIn(hostIn),
        .hostDataOut(hostDataOut), .hostDataOe(hostDataOe), .flashDataIn(flashDataIn),
        .flashAddr(flashAddr), .flashCtl(flashCtl), .flashDataOut(flashDataOut),
        .flashDataOe(flashDataOe));
    iofp_host_model #(.IO_BASE(BASE)) u_iofp_host_model (.core_clk(core_clk), .hostIn(hostIn));

    // ************************************************************
    // Flash array beside the port
    // ************************************************************
    // A deselected array floats, so it shows a toggling word rather than the last one.
    initial flashDataIn = 16'h0000;
    always @(posedge core_clk) begin
        if (!(&flashCtl.ceN) && !flashCtl.weN) arr[flashAddr] = flashDataOut;
        if (!(&flashCtl.ceN) && !flashCtl.oeN) begin
            flashDataIn <= arr.exists(flashAddr) ? arr[flashAddr]
                         : 16'hA5C3 ^ flashAddr[15:0] ^ flashAddr[31:16];
        end else begin
            flashDataIn <= ~flashDataIn;
        end
    end

    // ************************************************************
    // Checking
    // ************************************************************
    task automatic check(input logic [47:0] got, input logic [47:0] exp);
        tests_run++;
        if (got !== exp) begin
            mismatches++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : check

    task automatic give_verdict();
        $display("Comparisons %0d, mismatches %0d", tests_run, mismatches);
        if (mismatches == 0 && tests_run > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : give_verdict

    function automatic logic [47:0] endNote(ref logic [47:0] q[$]);
        return (q.size() > 0) ? q.pop_front() : 48'hDEAD_0000_0000;
    endfunction : endNote

    // An access that ends with no note pending was not asked for and is flagged.
    always @(negedge core_clk) begin
        if (rdOn && !hostDataOe) begin
            check(seen, endNote(rdQ));
            check({40'h0, seenCe}, {40'h0, ~(8'h01 << seenAddr[DEV_ADDR_W_DEF +: 3])});
        end
        if (wrOn && !flashDataOe) begin
            check(seen, endNote(wrQ));
            check({40'h0, seenCe}, {40'h0, ~(8'h01 << seenAddr[DEV_ADDR_W_DEF +: 3])});
        end
        if (reset_n && !hostDataOe && !flashDataOe) begin
            check({37'h0, flashCtl}, {37'h0, FLASH_IDLE});
        end
        rdOn = hostDataOe;
        wrOn = flashDataOe;
        seenAddr = flashAddr;
        seenCe = flashCtl.ceN;
        seen = {flashAddr, hostDataOe ? hostDataOut : flashDataOut};
    end

    // ************************************************************
    // Stimulus
    // ************************************************************
    function automatic logic [15:0] expWord(input logic [31:0] a);
        return wrote.exists(a) ? wrote[a] : 16'hA5C3 ^ a[15:0] ^ a[31:16];
    endfunction : expWord

    task automatic rd(input logic [2:0] p, inout logic [31:0] a);
        rdQ.push_back({a, expWord(a)});
        u_iofp_host_model.busCycle(BASE + {7'h0, p}, 1'b1, 1'b0, 16'h0000);
        if (p == 3'd3) a = a + 32'h1;
    endtask : rd

    task automatic wr2(input logic [31:0] a, input logic [15:0] d);
        wrQ.push_back({a, d});
        wrote[a] = d;
        u_iofp_host_model.busCycle(BASE + 10'h2, 1'b1, 1'b1, d);
    endtask : wr2

    initial begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end

    initial begin
        repeat (10000) @(posedge core_clk);
        mismatches++;
        give_verdict();
    end

    initial begin
        logic [31:0] a;
        reset_n = 1'b0;
        clkEn = 1'b1;
        mismatches = 0;
        tests_run = 0;
        void'($urandom(32'hc919));
        repeat (5) @(posedge core_clk);
        #1;
        check({16'h0, flashAddr}, {16'h0, ADDR_RESET});
        reset_n = 1'b1;
        a = $urandom;
        u_iofp_host_model.loadAddr(a);
        wr2(a, 16'($urandom));
        rd(3'd2, a);
        rd(3'd2, a);
        repeat (4) rd(3'd3, a);
        // Streaming across both 16-bit halves and a chip-enable boundary.
        a = 32'h00FF_FFFE;
        u_iofp_host_model.loadAddr(a);
        repeat (4) rd(3'd3, a);
        // A frozen clock enable holds a read off until the enable returns.
        fork
            rd(3'd3, a);
            begin
                repeat (4) @(posedge core_clk);
                #1;
                clkEn = 1'b0;
                repeat (6) @(posedge core_clk);
                #1;
                check({47'h0, hostDataOe}, 48'h0);
                clkEn = 1'b1;
            end
        join
        // Refused cycles must leave the address and both queues alone.
        u_iofp_host_model.busCycle(BASE + 10'h3, 1'b0, 1'b0, 16'h0000);
        u_iofp_host_model.busCycle(BASE + 10'h8, 1'b1, 1'b0, 16'h0000);
        for (int p = 4; p < 8; p++) begin
            u_iofp_host_model.busCycle(BASE + 10'(p), 1'b1, 1'b0, 16'h0000);
        end
        u_iofp_host_model.busCycle(BASE + 10'h0, 1'b1, 1'b0, 16'h0000);
        u_iofp_host_model.busCycle(BASE + 10'h3, 1'b1, 1'b1, 16'h1234);
        u_iofp_host_model.busCycle(BASE + 10'h0, 1'b0, 1'b1, 16'($urandom));
        rd(3'd3, a);
        // A reset in mid-run must return the counter to zero.
        reset_n = 1'b0;
        repeat (2) @(posedge core_clk);
        #1;
        check({16'h0, flashAddr}, {16'h0, ADDR_RESET});
        reset_n = 1'b1;
        for (int i = 0; i < 8; i++) begin
            a = $urandom;
            a[24:22] = i[2:0];
            u_iofp_host_model.loadAddr(a);
            wr2(a, 16'($urandom));
            rd(3'd2, a);
            rd(3'd3, a);
        end
        repeat (10) @(posedge core_clk);
        check(48'(rdQ.size() + wrQ.size()), 48'h0);
        give_verdict();
    end
endmodule : iofp_port_tb_top
`default_nettype wire
